// *** verilog/low_power_mode_controller.v ***
// Summary of operation
// - Sleep halts core only, any interrupt or peripheral wake resumes
// - Stop gates core clocks, fast oscillators off except RC on bus request
// - rtc, tamper, watchdog, sleep timer stay alive
// - Stop 0 keeps main regulator; Stop 1 lower
// - brownout low-power option in Stop 1, Standby
// - wake from Stop/Standby selects 16 MHz RC
// - Standby turns regulator and core domain off
// - brownout detector always on in Standby
// - Standby holds pins pull-up, down or float
// - Standby loses state except chosen SRAM, radio
// - Standby exits on reset, watchdog, pin, rtc, tamper
// - radio retention adds sleep timer exit
// - Stop 0 peripherals autonomous, radio needs range 1
// - Stop 1 bus clock request moves to Stop 0
// - each kernel clock on while its own request, off in Standby
// - system clock request enables RC, Stop 0
// - no bus request returns Stop 1
// - hardware triggers start peripherals, interrupts wake
// - DMA linked list runs in Stop 0
// - DMA memory transfers triggered or gated
`timescale 1ns/1ps
`include "lpm_defines.vh"

module low_power_mode_controller #(
  parameter NPER  = 6,
  parameter NWAKE = `WAKE_PINS
) (
  // clock and reset
  input  wire             mclk,
  input  wire             sys_rst,
  // software control
  input  wire             sleep_enter,
  input  wire [2:0]       lp_mode_sel,
  input  wire             deep_enter,
  input  wire [1:0]       run_clk_src,
  input  wire             bor_ulp_cfg,
  input  wire [1:0]       pin_hold_cfg,
  input  wire             sram_bank_one_keep,
  input  wire             sram_bank_two_keep,
  input  wire             radio_keep,
  input  wire             volt_range,
  // wake and event sources
  input  wire             any_irq_event,
  input  wire             external_reset_pin_n,
  input  wire             watchdog_event,
  input  wire [NWAKE-1:0] wakeup_pin,
  input  wire [NWAKE-1:0] wakeup_pin_falling,
  input  wire [NWAKE-1:0] wakeup_pin_enable,
  input  wire             rtc_event,
  input  wire             tamper_event,
  input  wire             radio_sleep_timer_event,
  input  wire             periph_wake_irq,
  // autonomous peripheral requests
  input  wire [NPER-1:0]  kernel_clk_req,
  input  wire [NPER-1:0]  bus_clk_req,
  input  wire [NPER-1:0]  hw_trigger,
  input  wire             dma_mem_trigger,
  input  wire             dma_gate_trigger,
  // mode and power status
  output reg  [2:0]       power_mode,
  output reg              core_clk_en,
  output reg              periph_clk_en,
  output reg              core_domain_pwr,
  output reg              main_regulator_on,
  output reg              lp_regulator_on,
  output reg              pll_en,
  output reg              internal_16mhz_rc_osc_en,
  output reg              external_32mhz_crystal_osc_en,
  output reg              low_speed_osc_en,
  output reg  [1:0]       sys_clk_src,
  output reg              always_on_blocks_en,
  output reg              brownout_detector_en,
  output reg              brownout_detector_ulp,
  output reg  [1:0]       pin_hold_mode,
  output reg              sram_bank_one_pwr,
  output reg              sram_bank_two_pwr,
  output reg              radio_pwr,
  output reg              radio_autonomous,
  output reg              state_retained,
  // autonomous operation
  output reg  [NPER-1:0]  kernel_clk_en,
  output reg  [NPER-1:0]  periph_start,
  output reg              bus_clk_en,
  output reg              dma_en,
  output reg              dma_mem_start,
  output reg              dma_periph_gate,
  output reg              woke_from_standby
);

  // ==========================================================
  // state
  // ==========================================================
  localparam [2:0] ST_RUN     = `ST_RUN;
  localparam [2:0] ST_SLEEP   = `ST_SLEEP;
  localparam [2:0] ST_STOP0   = `ST_STOP0;
  localparam [2:0] ST_STOP1   = `ST_STOP1;
  localparam [2:0] ST_STANDBY = `ST_STANDBY;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        radio_kept;
  reg        next_radio_kept;
  reg        stop1_chosen;
  reg        next_stop1_chosen;
  reg  [1:0] next_sys_clk_src;
  wire       pin_edge;
  wire       any_bus_req;
  wire       standby_exit;
  wire       stop_exit;

  wake_edge_detect #(
    .N (NWAKE)
  ) u_wake (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .pin_level   (wakeup_pin),
    .pin_falling (wakeup_pin_falling),
    .pin_enable  (wakeup_pin_enable),
    .edge_seen   (pin_edge)
  );

  assign any_bus_req = |bus_clk_req;

  assign standby_exit = ~external_reset_pin_n | watchdog_event |
                        pin_edge | rtc_event | tamper_event |
                        (radio_kept & radio_sleep_timer_event);

  assign stop_exit = any_irq_event | periph_wake_irq | standby_exit;

  // ==========================================================
  // mode sequencing
  // ==========================================================
  always @* begin
    next_state        = state;
    next_radio_kept   = radio_kept;
    next_stop1_chosen = stop1_chosen;
    case (state)
      ST_RUN: begin
        // low power only on software request
        if (sleep_enter) begin
          next_state = ST_SLEEP;
        end else if (deep_enter) begin
          case (lp_mode_sel)
            `MODE_STOP0: begin
              next_state        = ST_STOP0;
              next_stop1_chosen = 1'b0;
            end
            `MODE_STOP1: begin
              // pending bus request lands in Stop 0
              next_state        = any_bus_req ? ST_STOP0 : ST_STOP1;
              next_stop1_chosen = 1'b1;
            end
            `MODE_STANDBY: begin
              next_state      = ST_STANDBY;
              next_radio_kept = radio_keep;
            end
            default: next_state = ST_RUN;
          endcase
        end
      end
      ST_SLEEP: begin
        if (any_irq_event | periph_wake_irq) begin
          next_state = ST_RUN;
        end
      end
      ST_STOP0: begin
        if (stop_exit) begin
          next_state = ST_RUN;
        end else if (stop1_chosen & ~any_bus_req) begin
          next_state = ST_STOP1;
        end
      end
      ST_STOP1: begin
        if (stop_exit) begin
          next_state = ST_RUN;
        end else if (any_bus_req) begin
          next_state = ST_STOP0;
        end
      end
      ST_STANDBY: begin
        if (standby_exit) begin
          next_state      = ST_RUN;
          next_radio_kept = 1'b0;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state          <= ST_RUN;
      radio_kept     <= 1'b0;
      stop1_chosen   <= 1'b0;
    end else begin
      state          <= next_state;
      radio_kept     <= next_radio_kept;
      stop1_chosen   <= next_stop1_chosen;
    end
  end

  // ==========================================================
  // power, clock and retention controls
  // ==========================================================
  // wake on 16 MHz RC
  always @* begin
    next_sys_clk_src = sys_clk_src;
    if ((state != ST_RUN) && (state != ST_SLEEP) &&
        (next_state == ST_RUN)) begin
      next_sys_clk_src = `CLK_SRC_RC16;
    end else if (next_state == ST_RUN) begin
      next_sys_clk_src = run_clk_src;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      power_mode                    <= `MODE_RUN;
      core_clk_en                   <= 1'b1;
      periph_clk_en                 <= 1'b1;
      core_domain_pwr               <= 1'b1;
      main_regulator_on             <= 1'b1;
      lp_regulator_on               <= 1'b0;
      pll_en                        <= 1'b0;
      internal_16mhz_rc_osc_en      <= 1'b1;
      external_32mhz_crystal_osc_en <= 1'b0;
      low_speed_osc_en              <= 1'b1;
      sys_clk_src                   <= `CLK_SRC_RC16;
      always_on_blocks_en           <= 1'b1;
      brownout_detector_en          <= 1'b1;
      brownout_detector_ulp         <= 1'b0;
      pin_hold_mode                 <= `PIN_HOLD_FLOAT;
      sram_bank_one_pwr             <= 1'b1;
      sram_bank_two_pwr             <= 1'b1;
      radio_pwr                     <= 1'b1;
      radio_autonomous              <= 1'b0;
      state_retained                <= 1'b1;
      woke_from_standby             <= 1'b0;
    end else begin
      power_mode           <= next_state;
      low_speed_osc_en     <= 1'b1;
      always_on_blocks_en  <= 1'b1;
      brownout_detector_en <= 1'b1;
      pin_hold_mode        <= `PIN_HOLD_FLOAT;
      // only core clock stops in Sleep
      core_clk_en          <= (next_state == ST_RUN);
      periph_clk_en        <= (next_state == ST_RUN) |
                              (next_state == ST_SLEEP);
      core_domain_pwr      <= (next_state != ST_STANDBY);
      // main regulator in Stop 0 only among deep modes
      main_regulator_on    <= (next_state == ST_RUN) |
                              (next_state == ST_SLEEP) |
                              (next_state == ST_STOP0);
      lp_regulator_on      <= (next_state == ST_STOP1) |
                              ((next_state == ST_STANDBY) &
                               (sram_bank_one_keep |
                                sram_bank_two_keep | radio_keep));
      brownout_detector_ulp <= bor_ulp_cfg &
                               ((next_state == ST_STOP1) |
                                (next_state == ST_STANDBY));
      radio_autonomous     <= (next_state == ST_STOP0) &
                              (volt_range == `VRANGE_1);
      woke_from_standby    <= (state == ST_STANDBY) &
                              (next_state == ST_RUN);
      sys_clk_src          <= next_sys_clk_src;
      case (next_state)
        ST_RUN, ST_SLEEP: begin
          // enables follow the new source, never a stale one
          pll_en                        <= (next_sys_clk_src == `CLK_SRC_PLL);
          external_32mhz_crystal_osc_en <= (next_sys_clk_src != `CLK_SRC_RC16);
          internal_16mhz_rc_osc_en      <= 1'b1;
          sram_bank_one_pwr             <= 1'b1;
          sram_bank_two_pwr             <= 1'b1;
          radio_pwr                     <= 1'b1;
          state_retained                <= 1'b1;
        end
        ST_STOP0, ST_STOP1: begin
          // RC only for bus clock request
          pll_en                        <= 1'b0;
          external_32mhz_crystal_osc_en <= 1'b0;
          internal_16mhz_rc_osc_en      <= any_bus_req;
          sram_bank_one_pwr             <= 1'b1;
          sram_bank_two_pwr             <= 1'b1;
          radio_pwr                     <= 1'b1;
          state_retained                <= 1'b1;
        end
        default: begin
          pll_en                        <= 1'b0;
          external_32mhz_crystal_osc_en <= 1'b0;
          internal_16mhz_rc_osc_en      <= 1'b0;
          pin_hold_mode                 <= pin_hold_cfg;
          sram_bank_one_pwr             <= sram_bank_one_keep;
          sram_bank_two_pwr             <= sram_bank_two_keep;
          radio_pwr                     <= radio_keep;
          state_retained                <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // background autonomous operation
  // ==========================================================
  always @(posedge mclk) begin
    if (sys_rst) begin
      kernel_clk_en   <= {NPER{1'b0}};
      periph_start    <= {NPER{1'b0}};
      bus_clk_en      <= 1'b0;
      dma_en          <= 1'b1;
      dma_mem_start   <= 1'b0;
      dma_periph_gate <= 1'b0;
    end else begin
      kernel_clk_en   <= (next_state == ST_STANDBY) ?
                         {NPER{1'b0}} : kernel_clk_req;
      periph_start    <= (next_state == ST_STANDBY) ?
                         {NPER{1'b0}} : hw_trigger;
      bus_clk_en      <= (next_state == ST_STOP0) ? any_bus_req :
                         (next_state != ST_STOP1) &&
                         (next_state != ST_STANDBY);
      dma_en          <= (next_state == ST_RUN) |
                         (next_state == ST_SLEEP) |
                         (next_state == ST_STOP0);
      dma_mem_start   <= dma_mem_trigger & (next_state != ST_STOP1) &
                         (next_state != ST_STANDBY);
      dma_periph_gate <= dma_gate_trigger;
    end
  end

endmodule // low_power_mode_controller

// *** verilog/lpm_defines.vh ***
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

// power modes requested by software / current mode encoding
`define MODE_RUN        3'h0
`define MODE_SLEEP      3'h1
`define MODE_STOP0      3'h2
`define MODE_STOP1      3'h3
`define MODE_STANDBY    3'h4

// system clock source encoding
`define CLK_SRC_RC16    2'h0
`define CLK_SRC_XTAL32  2'h1
`define CLK_SRC_PLL     2'h2

// standby pin hold encoding
`define PIN_HOLD_FLOAT  2'h0
`define PIN_HOLD_UP     2'h1
`define PIN_HOLD_DOWN   2'h2

// fsm state codes
`define ST_RUN          3'h0
`define ST_SLEEP        3'h1
`define ST_STOP0        3'h2
`define ST_STOP1        3'h3
`define ST_STANDBY      3'h4

// voltage range 1 encoding
`define VRANGE_1        1'h0

// wake-up pin edge detection helper width
`define WAKE_PINS       8

`endif

// *** verilog/wake_edge_detect.v ***
`timescale 1ns/1ps
`include "lpm_defines.vh"

module wake_edge_detect #(
  parameter N = `WAKE_PINS
) (
  // clock and reset
  input  wire         mclk,
  input  wire         sys_rst,
  // pins and polarity
  input  wire [N-1:0] pin_level,
  input  wire [N-1:0] pin_falling,
  input  wire [N-1:0] pin_enable,
  // result
  output reg          edge_seen
);

  reg [N-1:0] last_level;

  always @(posedge mclk) begin
    if (sys_rst) begin
      last_level <= {N{1'b0}};
      edge_seen  <= 1'b0;
    end else begin
      last_level <= pin_level;
      // rising when polarity bit low, falling when high
      edge_seen  <= |(pin_enable &
                      ((~pin_falling & pin_level & ~last_level) |
                       (pin_falling & ~pin_level & last_level)));
    end
  end

endmodule // wake_edge_detect

// *** dv/lpm_periph_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// autonomous peripheral request model
module lpm_periph_model #(
  parameter NPER = 6
) (
  // clock
  input  logic            mclk,
  // wishes from the bench
  input  logic [NPER-1:0] bus_want,
  input  logic [NPER-1:0] kern_want,
  input  logic [NPER-1:0] trig_want,
  input  logic            wake_want,
  // requests to the controller
  output logic [NPER-1:0] kernel_clk_req,
  output logic [NPER-1:0] bus_clk_req,
  output logic [NPER-1:0] hw_trigger,
  output logic            periph_wake_irq
);
  always @(negedge mclk) begin
    kernel_clk_req  <= kern_want;
    bus_clk_req     <= bus_want;
    hw_trigger      <= trig_want;
    periph_wake_irq <= wake_want;
  end
endmodule // lpm_periph_model

// *** dv/lpm_checker_asserts.sv ***
`timescale 1ns/1ps
`include "lpm_defines.vh"
// ==========================================================
// power mode checker
module lpm_checker #(
  parameter NPER = 6
) (
  // clock and reset
  input logic            mclk,
  input logic            sys_rst,
  // inputs watched
  input logic            any_irq_event,
  input logic            periph_wake_irq,
  input logic            rtc_event,
  input logic            tamper_event,
  input logic            watchdog_event,
  input logic            external_reset_pin_n,
  input logic            volt_range,
  input logic [NPER-1:0] kernel_clk_req,
  input logic [NPER-1:0] bus_clk_req,
  // outputs watched
  input logic [2:0]      power_mode,
  input logic            core_clk_en,
  input logic            periph_clk_en,
  input logic            core_domain_pwr,
  input logic            main_regulator_on,
  input logic            pll_en,
  input logic            internal_16mhz_rc_osc_en,
  input logic            external_32mhz_crystal_osc_en,
  input logic            low_speed_osc_en,
  input logic [1:0]      sys_clk_src,
  input logic            brownout_detector_en,
  input logic            brownout_detector_ulp,
  input logic            radio_autonomous,
  input logic [NPER-1:0] kernel_clk_en,
  input logic            bus_clk_en
);
  wire quiet = !any_irq_event && !periph_wake_irq && !rtc_event &&
               !tamper_event && !watchdog_event && external_reset_pin_n;
  reg  auto_stop0;
  // stop 0 reached from stop 1 by a request
  always @(posedge mclk) begin
    if (sys_rst)
      auto_stop0 <= 1'b0;
    else if (power_mode == `MODE_STOP1)
      auto_stop0 <= 1'b1;
    else if (power_mode != `MODE_STOP0)
      auto_stop0 <= 1'b0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sleep_core_a: assert property (power_mode == `MODE_SLEEP |->
    !core_clk_en && periph_clk_en) else $error("sleep clocks wrong");
  sleep_wake_a: assert property ((power_mode == `MODE_SLEEP) &&
    any_irq_event |=> power_mode == `MODE_RUN) else $error("no sleep wake");
  stop_clocks_a: assert property (power_mode inside
    {`MODE_STOP0, `MODE_STOP1} |-> !core_clk_en && !pll_en &&
    !external_32mhz_crystal_osc_en) else $error("stop clocks alive");
  slow_osc_a: assert property (low_speed_osc_en &&
    brownout_detector_en) else $error("slow osc or brownout off");
  stop0_reg_a: assert property (power_mode == `MODE_STOP0 |->
    main_regulator_on) else $error("stop0 regulator off");
  bor_ulp_a: assert property (brownout_detector_ulp |-> power_mode
    inside {`MODE_STOP1, `MODE_STANDBY}) else $error("brownout ulp");
  wake_rc_a: assert property ($past(power_mode) inside {`MODE_STOP0,
    `MODE_STOP1, `MODE_STANDBY} && power_mode == `MODE_RUN |->
    sys_clk_src == `CLK_SRC_RC16) else $error("wake clock not rc");
  standby_off_a: assert property (power_mode == `MODE_STANDBY |->
    !core_domain_pwr && !main_regulator_on && !pll_en &&
    !internal_16mhz_rc_osc_en && !external_32mhz_crystal_osc_en)
    else $error("standby power on");
  radio_auto_a: assert property (radio_autonomous |->
    power_mode == `MODE_STOP0 && $past(volt_range) == `VRANGE_1)
    else $error("radio autonomous wrongly");
  to_stop0_a: assert property (power_mode == `MODE_STOP1 &&
    (|bus_clk_req) && quiet |=> power_mode == `MODE_STOP0 && bus_clk_en
    && internal_16mhz_rc_osc_en) else $error("no move to stop0");
  back_stop1_a: assert property (auto_stop0 &&
    power_mode == `MODE_STOP0 && !(|bus_clk_req) && quiet |=>
    power_mode == `MODE_STOP1 && !bus_clk_en) else $error("no stop1 return");
  kernel_follow_a: assert property (power_mode inside
    {`MODE_STOP0, `MODE_STOP1} ##1 power_mode inside {`MODE_STOP0,
    `MODE_STOP1} |-> kernel_clk_en == $past(kernel_clk_req))
    else $error("kernel clock mismatch");
  sleep_c: cover property (power_mode == `MODE_SLEEP);
  stop0_c: cover property (auto_stop0 && power_mode == `MODE_STOP0);
  standby_c: cover property (power_mode == `MODE_STANDBY);
endmodule // lpm_checker

bind low_power_mode_controller lpm_checker #(.NPER(NPER)) lpm_checker_i (
  .mclk(mclk), .sys_rst(sys_rst), .any_irq_event(any_irq_event),
  .periph_wake_irq(periph_wake_irq), .rtc_event(rtc_event),
  .tamper_event(tamper_event), .watchdog_event(watchdog_event),
  .external_reset_pin_n(external_reset_pin_n), .volt_range(volt_range),
  .kernel_clk_req(kernel_clk_req), .bus_clk_req(bus_clk_req),
  .power_mode(power_mode), .core_clk_en(core_clk_en),
  .periph_clk_en(periph_clk_en), .core_domain_pwr(core_domain_pwr),
  .main_regulator_on(main_regulator_on), .pll_en(pll_en),
  .internal_16mhz_rc_osc_en(internal_16mhz_rc_osc_en),
  .external_32mhz_crystal_osc_en(external_32mhz_crystal_osc_en),
  .low_speed_osc_en(low_speed_osc_en), .sys_clk_src(sys_clk_src),
  .brownout_detector_en(brownout_detector_en),
  .brownout_detector_ulp(brownout_detector_ulp),
  .radio_autonomous(radio_autonomous), .kernel_clk_en(kernel_clk_en),
  .bus_clk_en(bus_clk_en));

// *** dv/low_power_mode_controller_test.sv ***
`timescale 1ns/1ps
`include "lpm_defines.vh"
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
// ==========================================================
// bench top
module low_power_mode_controller_test;
  int n_mismatch = 0;
  int n_compared = 0;
  logic mclk, sys_rst, sleep_enter, deep_enter, bor_ulp_cfg, radio_keep;
  logic sram_bank_one_keep, sram_bank_two_keep, volt_range, any_irq_event;
  logic external_reset_pin_n, watchdog_event, rtc_event, tamper_event;
  logic radio_sleep_timer_event, dma_mem_trigger, dma_gate_trigger;
  logic wake_want, periph_wake_irq, dma_en, dma_mem_start, dma_periph_gate;
  logic [2:0] lp_mode_sel, power_mode;
  logic [1:0] run_clk_src, pin_hold_cfg, sys_clk_src, pin_hold_mode;
  logic [7:0] wakeup_pin, wakeup_pin_falling, wakeup_pin_enable;
  logic [5:0] bus_want, kern_want, trig_want, kernel_clk_req, bus_clk_req;
  logic [5:0] hw_trigger, kernel_clk_en, periph_start;
  logic core_clk_en, periph_clk_en, core_domain_pwr, main_regulator_on;
  logic lp_regulator_on, pll_en, internal_16mhz_rc_osc_en, bus_clk_en;
  logic external_32mhz_crystal_osc_en, brownout_detector_en, radio_pwr;
  logic brownout_detector_ulp, sram_bank_one_pwr, sram_bank_two_pwr;
  logic radio_autonomous, always_on_blocks_en, state_retained;
  logic woke_from_standby;
  low_power_mode_controller low_power_mode_controller_i (.mclk, .sys_rst,
    .sleep_enter, .lp_mode_sel, .deep_enter, .run_clk_src, .bor_ulp_cfg,
    .pin_hold_cfg, .sram_bank_one_keep, .sram_bank_two_keep, .radio_keep,
    .volt_range, .any_irq_event, .external_reset_pin_n, .watchdog_event,
    .wakeup_pin, .wakeup_pin_falling, .wakeup_pin_enable, .rtc_event,
    .tamper_event, .radio_sleep_timer_event, .periph_wake_irq,
    .kernel_clk_req, .bus_clk_req, .hw_trigger, .dma_mem_trigger,
    .dma_gate_trigger, .power_mode, .core_clk_en, .periph_clk_en,
    .core_domain_pwr, .main_regulator_on, .lp_regulator_on, .pll_en,
    .internal_16mhz_rc_osc_en, .external_32mhz_crystal_osc_en,
    .low_speed_osc_en(), .sys_clk_src, .always_on_blocks_en,
    .brownout_detector_en, .brownout_detector_ulp, .pin_hold_mode,
    .sram_bank_one_pwr, .sram_bank_two_pwr, .radio_pwr, .radio_autonomous,
    .state_retained, .kernel_clk_en, .periph_start, .bus_clk_en, .dma_en,
    .dma_mem_start, .dma_periph_gate, .woke_from_standby);
  lpm_periph_model lpm_periph_model_i (.mclk, .bus_want, .kern_want,
    .trig_want, .wake_want, .kernel_clk_req, .bus_clk_req, .hw_trigger,
    .periph_wake_irq);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task enter(input logic [2:0] sel);
    deep_enter = 1'b1;
    lp_mode_sel = sel;
    step(1);
    deep_enter = 1'b0;
  endtask
  task stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    {sleep_enter, deep_enter, bor_ulp_cfg, radio_keep, any_irq_event} = '0;
    {sram_bank_one_keep, sram_bank_two_keep, watchdog_event} = '0;
    {rtc_event, tamper_event, radio_sleep_timer_event} = '0;
    {dma_mem_trigger, dma_gate_trigger, wake_want} = '0;
    {bus_want, kern_want, trig_want, wakeup_pin, wakeup_pin_falling} = '0;
    sys_rst = 1'b1;
    external_reset_pin_n = 1'b1;
    volt_range = `VRANGE_1;
    lp_mode_sel = `MODE_RUN;
    run_clk_src = `CLK_SRC_RC16;
    pin_hold_cfg = `PIN_HOLD_UP;
    wakeup_pin_enable = 8'h01;
    step(2);
    sys_rst = 1'b0;
    `CHK(power_mode, `MODE_RUN, "run after reset")
    `CHK(sys_clk_src, `CLK_SRC_RC16, "reset clock")
    enter(3'h5);
    `CHK(power_mode, `MODE_RUN, "bad select left run")
    sleep_enter = 1'b1;
    step(1);
    sleep_enter = 1'b0;
    `CHK({core_clk_en, periph_clk_en}, 2'h1, "sleep clocks")
    enter(`MODE_STOP1);
    `CHK(power_mode, `MODE_SLEEP, "sleep kept")
    any_irq_event = 1'b1;
    step(1);
    any_irq_event = 1'b0;
    `CHK(power_mode, `MODE_RUN, "sleep wake")
    run_clk_src = `CLK_SRC_PLL;
    step(1);
    `CHK({sys_clk_src, pll_en}, 3'h5, "pll run clock")
    enter(`MODE_STOP0);
    `CHK({main_regulator_on, pll_en}, 2'h2, "stop0 power")
    `CHK({radio_autonomous, dma_en}, 2'h3, "stop0 autonomy")
    volt_range = ~`VRANGE_1;
    step(1);
    `CHK(radio_autonomous, 1'b0, "radio needs range 1")
    any_irq_event = 1'b1;
    step(1);
    any_irq_event = 1'b0;
    `CHK(sys_clk_src, `CLK_SRC_RC16, "wake clock")
    bor_ulp_cfg = 1'b1;
    enter(`MODE_STOP1);
    `CHK(main_regulator_on, 1'b0, "stop1 regulator")
    `CHK(internal_16mhz_rc_osc_en, 1'b0, "stop1 rc off")
    `CHK(brownout_detector_ulp, 1'b1, "stop1 ulp")
    `CHK({always_on_blocks_en, state_retained}, 2'h3, "stop1 keeps")
    `CHK(dma_en, 1'b0, "stop1 dma off")
    kern_want <= 6'h05;
    step(2);
    `CHK(kernel_clk_en, 6'h05, "kernel clock on")
    `CHK(power_mode, `MODE_STOP1, "kernel only stays")
    kern_want <= 6'h00;
    bus_want <= 6'h02;
    step(2);
    `CHK(kernel_clk_en, 6'h00, "kernel clock off")
    `CHK(power_mode, `MODE_STOP0, "bus request")
    `CHK({bus_clk_en, internal_16mhz_rc_osc_en}, 2'h3, "bus clock")
    trig_want <= 6'h08;
    dma_mem_trigger = 1'b1;
    dma_gate_trigger = 1'b1;
    step(2);
    `CHK(periph_start, 6'h08, "trigger start")
    `CHK({dma_mem_start, dma_periph_gate}, 2'h3, "dma triggers")
    {dma_mem_trigger, dma_gate_trigger} = 2'h0;
    trig_want <= 6'h00;
    bus_want <= 6'h00;
    step(2);
    `CHK(power_mode, `MODE_STOP1, "back to stop1")
    wake_want <= 1'b1;
    step(2);
    wake_want <= 1'b0;
    `CHK(power_mode, `MODE_RUN, "peripheral wake")
    {sram_bank_one_keep, radio_keep} = 2'h3;
    enter(`MODE_STANDBY);
    `CHK({core_domain_pwr, internal_16mhz_rc_osc_en}, 2'h0, "off")
    `CHK(brownout_detector_en, 1'b1, "brownout on")
    `CHK(pin_hold_mode, `PIN_HOLD_UP, "pin pull-up")
    `CHK({sram_bank_one_pwr, sram_bank_two_pwr}, 2'h2, "sram keep")
    `CHK({radio_pwr, lp_regulator_on}, 2'h3, "radio keep")
    `CHK({always_on_blocks_en, state_retained}, 2'h2, "lost state")
    radio_sleep_timer_event = 1'b1;
    step(1);
    radio_sleep_timer_event = 1'b0;
    `CHK(power_mode, `MODE_RUN, "sleep timer exit")
    `CHK(woke_from_standby, 1'b1, "standby wake flag")
    {sram_bank_one_keep, radio_keep} = 2'h0;
    pin_hold_cfg = `PIN_HOLD_DOWN;
    for (int k = 0; k < 6; k++) begin
      enter(`MODE_STANDBY);
      `CHK(pin_hold_mode, `PIN_HOLD_DOWN, "pin pull-down")
      `CHK(lp_regulator_on, 1'b0, "no retention")
      external_reset_pin_n = (k != 0);
      watchdog_event = (k == 1);
      rtc_event = (k == 2);
      tamper_event = (k == 3);
      wakeup_pin[0] = (k == 4);
      radio_sleep_timer_event = (k == 5);
      step(2);
      {watchdog_event, rtc_event, tamper_event} = 3'h0;
      {external_reset_pin_n, radio_sleep_timer_event} = 2'h2;
      wakeup_pin[0] = 1'b0;
      `CHK(power_mode, (k == 5) ? `MODE_STANDBY : `MODE_RUN, "exit")
      rtc_event = 1'b1;
      step(1);
      rtc_event = 1'b0;
    end
    enter(`MODE_STOP1);
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    `CHK(power_mode, `MODE_RUN, "run after second reset")
    stop_test;
  end
endmodule // low_power_mode_controller_test
